// ===== src/tx_dma_pkg.sv
// Constants, layouts and states of the transmit descriptor engine.
// Assumes a single 10 MHz clock shared by bus, memory port and link.
//
// Function
// - Descriptors enabled during activity are picked up when the pointer gets there.
// - A disabled descriptor clears the channel enable and halts fetching.
// - Calculate-CRC flag appends a CRC after header and after data.
// - Link error flag is written back as one on error, zero otherwise.
// - Descriptor interrupt flag plus control interrupt enable gives an interrupt after sending.
// - Pointer steps one descriptor, or returns to table base when wrap is set.
// - Descriptor enable marks it valid; engine clears it when the packet completes.
// - Leading header bytes counted by the non-CRC field skip the header CRC.
// - Header byte count zero means no header portion.
// - Header fetch starts at any byte address, no alignment.
// - Data length of 24 bits; zero means no data portion.
// - Both lengths zero sends nothing, not even the end-of-packet marker.
// - Descriptors are sixteen bytes; a table holds sixty-four.
// - Completion sets the packet-sent status bit and clears descriptor enable.
package tx_dma_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  TBASE_OFF     = 8'h04;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_IRQ_BIT  = 1;
  localparam int          CTRL_SENT_BIT = 2;
  localparam int          CTRL_BUSY_BIT = 3;
  localparam int          TBASE_LSB     = 10;
  localparam int          PTR_LSB       = 4;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

  // ==========================================================
  // Descriptor layout
  localparam int          PTR_W       = 6;
  localparam int          DESC_COUNT  = 64;
  localparam logic [3:0]  DESC_LOW    = 4'h0;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
  localparam int          EN_BIT      = 12;
  localparam int          LINK_ERR_BIT = 15;
  localparam logic [8:0]  EOP_CHAR    = 9'h100;
  localparam logic [7:0]  CRC_INIT    = 8'h00;
  localparam logic [7:0]  CRC_POLY_R  = 8'hE0;

  typedef struct packed {
    logic [14:0] rsvd;
    logic        calc_crc_flag;
    logic        link_error_flag;
    logic        desc_irq_enable;
    logic        wrap;
    logic        enable;
    logic [3:0]  non_crc;
    logic [7:0]  hdr_len;
  } desc_ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_FETCH = 4'h1,
    ST_BRD   = 4'h2,
    ST_BTX   = 4'h3,
    ST_CTX   = 4'h4,
    ST_NEXT  = 4'h5,
    ST_EOP   = 4'h6,
    ST_WB    = 4'h7
  } tx_state_t;

endpackage : tx_dma_pkg

// ===== src/rmap_crc8.sv
// Byte-serial RMAP CRC-8 register.
// Assumes clear and enable never pulse in the same cycle as a useful byte.
`timescale 1ns/1ps
module rmap_crc8
  import tx_dma_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] din,
  output logic      [7:0] crc
);

  // ==========================================================
  // Reflected polynomial, bit-serial unrolled per byte
  function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_R) : (r >> 1);
    end
    return r;
  endfunction : step

  always_ff @(posedge clk_sys) begin
    if (!rst_n || clr) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= step(crc, din);
    end
  end

endmodule : rmap_crc8

// ===== src/spw_tx_desc_dma.sv
// Transmit descriptor engine: AHB-Lite registers, word memory port, link char port.
// Assumes memory answers each request with a one-cycle ack and the link
// port runs on this same clock.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spw_tx_desc_dma
  import tx_dma_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             tx_valid,
  output logic      [8:0]  tx_data,
  input  wire logic        tx_ready,
  input  wire logic        link_error,
  output logic             irq_pulse
);

  // ==========================================================
  // State
  tx_state_t          state_q;
  logic [1:0]         widx_q;
  desc_ctrl_t         w0_q;
  logic [31:0]        hptr_q;
  logic [23:0]        dlen_q;
  logic [31:0]        dptr_q;
  logic [31:0]        ptr_q;
  logic [23:0]        cnt_q;
  logic [7:0]         idx_q;
  logic               phase_dat_q;
  logic               link_err_q;
  logic               tx_channel_enable_q;
  logic               irq_en_q;
  logic               packet_sent_flag_q;
  logic [PTR_W-1:0]   desc_ptr_q;
  logic [31:TBASE_LSB] base_q;
  logic               wr_pend_q;
  logic [7:0]         wr_off_q;
  logic [7:0]         crc;
  logic [31:0]        desc_addr;
  logic [7:0]         rd_byte;
  logic               crc_clr;
  logic               crc_en;
  logic               disable_evt;
  logic               done_evt;
  logic               aphase;
  logic               sw_ctrl_wr;
  logic               sw_tbase_wr;
  logic               sending;

  assign desc_addr   = {base_q, desc_ptr_q, DESC_LOW};
  // Big-endian lanes: byte 0 of a word sits in the top bits
  assign rd_byte     = mem_rdata[8*(3-ptr_q[1:0]) +: 8];
  assign crc_clr     = (state_q == ST_FETCH) || (state_q == ST_NEXT);
  assign crc_en      = (state_q == ST_BTX) && tx_valid && tx_ready &&
                       (phase_dat_q || (idx_q >= {4'h0, w0_q.non_crc}));
  assign disable_evt = (state_q == ST_FETCH) && mem_ack && (widx_q == 2'd0) &&
                       !mem_rdata[EN_BIT];
  assign done_evt    = (state_q == ST_WB) && mem_ack;
  assign aphase      = hsel && htrans[1] && hready;
  assign sw_ctrl_wr  = wr_pend_q && (wr_off_q == CTRL_OFF);
  assign sw_tbase_wr = wr_pend_q && (wr_off_q == TBASE_OFF);
  assign sending     = (state_q == ST_BRD) || (state_q == ST_BTX) ||
                       (state_q == ST_CTX) || (state_q == ST_EOP);

  rmap_crc8 u_crc (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (crc_clr),
    .en      (crc_en),
    .din     (tx_data[7:0]),
    .crc     (crc)
  );

  // ==========================================================
  // Descriptor sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      widx_q      <= 2'd0;
      w0_q        <= desc_ctrl_t'(RESET_WORD);
      hptr_q      <= RESET_WORD;
      dlen_q      <= 24'h00_0000;
      dptr_q      <= RESET_WORD;
      ptr_q       <= RESET_WORD;
      cnt_q       <= 24'h00_0000;
      idx_q       <= 8'h00;
      phase_dat_q <= 1'b0;
      link_err_q  <= 1'b0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= RESET_WORD;
      mem_wdata   <= RESET_WORD;
      tx_valid    <= 1'b0;
      tx_data     <= 9'h000;
      irq_pulse   <= 1'b0;
    end else begin
      irq_pulse <= 1'b0;
      if (sending && link_error) begin
        link_err_q <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          widx_q <= 2'd0;
          // Pointer is re-read each time, so late-enabled entries are seen
          if (tx_channel_enable_q) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= desc_addr + {28'h0, widx_q, 2'b00};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            widx_q  <= widx_q + 2'd1;
            case (widx_q)
              2'd0:    w0_q   <= desc_ctrl_t'(mem_rdata);
              2'd1:    hptr_q <= mem_rdata;
              2'd2:    dlen_q <= mem_rdata[23:0];
              default: dptr_q <= mem_rdata;
            endcase
            link_err_q  <= 1'b0;
            phase_dat_q <= 1'b0;
            idx_q       <= 8'h00;
            if (disable_evt) begin
              state_q <= ST_IDLE;
            end else if (widx_q == 2'd3) begin
              if (w0_q.hdr_len != 8'h00) begin
                ptr_q   <= hptr_q;
                cnt_q   <= {16'h0000, w0_q.hdr_len};
                state_q <= ST_BRD;
              end else if (dlen_q != 24'h00_0000) begin
                ptr_q       <= mem_rdata;
                cnt_q       <= dlen_q;
                phase_dat_q <= 1'b1;
                state_q     <= ST_BRD;
              end else begin
                state_q <= ST_WB;
              end
            end
          end
        end
        ST_BRD: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= {ptr_q[31:2], 2'b00};
          end else if (mem_ack) begin
            mem_req  <= 1'b0;
            tx_valid <= 1'b1;
            tx_data  <= {1'b0, rd_byte};
            state_q  <= ST_BTX;
          end
        end
        ST_BTX: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            ptr_q    <= ptr_q + 32'h0000_0001;
            cnt_q    <= cnt_q - 24'h00_0001;
            idx_q    <= idx_q + 8'h01;
            if (cnt_q != 24'h00_0001) begin
              state_q <= ST_BRD;
            end else if (w0_q.calc_crc_flag) begin
              state_q <= ST_CTX;
            end else begin
              state_q <= ST_NEXT;
            end
          end
        end
        ST_CTX: begin
          if (!tx_valid) begin
            tx_valid <= 1'b1;
            tx_data  <= {1'b0, crc};
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            state_q  <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (!phase_dat_q && (dlen_q != 24'h00_0000)) begin
            ptr_q       <= dptr_q;
            cnt_q       <= dlen_q;
            phase_dat_q <= 1'b1;
            state_q     <= ST_BRD;
          end else begin
            state_q <= ST_EOP;
          end
        end
        ST_EOP: begin
          if (!tx_valid) begin
            tx_valid <= 1'b1;
            tx_data  <= EOP_CHAR;
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            state_q  <= ST_WB;
          end
        end
        ST_WB: begin
          if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= desc_addr;
            mem_wdata <= {w0_q[31:LINK_ERR_BIT+1], link_err_q,
                          w0_q[LINK_ERR_BIT-1:EN_BIT+1],
                          1'b0, w0_q[EN_BIT-1:0]};
          end else if (mem_ack) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            irq_pulse <= w0_q.desc_irq_enable && irq_en_q;
            state_q   <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Control and pointer registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_channel_enable_q <= 1'b0;
      irq_en_q            <= 1'b0;
      packet_sent_flag_q  <= 1'b0;
    end else begin
      // Software set wins over the hardware clear in the same cycle
      if (sw_ctrl_wr && hwdata[CTRL_EN_BIT]) begin
        tx_channel_enable_q <= 1'b1;
      end else if (disable_evt) begin
        tx_channel_enable_q <= 1'b0;
      end
      if (sw_ctrl_wr) begin
        irq_en_q <= hwdata[CTRL_IRQ_BIT];
      end
      if (done_evt) begin
        packet_sent_flag_q <= 1'b1;
      end else if (sw_ctrl_wr && hwdata[CTRL_SENT_BIT]) begin
        packet_sent_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      desc_ptr_q <= '0;
      base_q     <= '0;
    end else if (done_evt) begin
      desc_ptr_q <= w0_q.wrap ? '0 : desc_ptr_q + 1'b1;
    end else if (sw_tbase_wr && (state_q == ST_IDLE) && !tx_channel_enable_q) begin
      // Table moves only while idle, avoids tearing an active fetch
      desc_ptr_q <= hwdata[PTR_LSB +: PTR_W];
      base_q     <= hwdata[31:TBASE_LSB];
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= 8'h00;
      hrdata    <= RESET_WORD;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= aphase && hwrite;
      wr_off_q  <= haddr[7:0];
      if (aphase && !hwrite) begin
        case (haddr[7:0])
          CTRL_OFF:  hrdata <= {28'h0, (state_q != ST_IDLE), packet_sent_flag_q,
                                irq_en_q, tx_channel_enable_q};
          TBASE_OFF: hrdata <= {base_q, desc_ptr_q, DESC_LOW};
          default:   hrdata <= RESET_WORD;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  a_disable_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
    disable_evt && !(sw_ctrl_wr && hwdata[0]) |=> !tx_channel_enable_q && state_q == ST_IDLE)
    else $error("disabled descriptor did not stop the channel");
  a_wb_clears_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mem_req && mem_we |-> !mem_wdata[EN_BIT] && mem_addr == desc_addr)
    else $error("write-back kept descriptor enable");
  a_link_err_written: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mem_req && mem_we |-> mem_wdata[LINK_ERR_BIT] == link_err_q)
    else $error("link error flag written wrong");
  a_ps_on_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_evt |=> packet_sent_flag_q)
    else $error("packet sent flag not set");
  a_irq_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_pulse |-> $past(done_evt) && w0_q.desc_irq_enable && $past(irq_en_q))
    else $error("interrupt without cause");
  a_ptr_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_evt && w0_q.wrap |=> desc_ptr_q == '0)
    else $error("wrap did not return to table base");
  a_ptr_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_evt && !w0_q.wrap |=> desc_ptr_q == $past(desc_ptr_q) + 1'b1)
    else $error("pointer did not step one descriptor");
  a_empty_silent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_FETCH && mem_ack && widx_q == 2'd3 && !disable_evt &&
    w0_q.hdr_len == 8'h00 && dlen_q == 24'h00_0000 |=> state_q == ST_WB && !tx_valid)
    else $error("empty descriptor sent something");
  a_char_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("link character dropped before acceptance");
  a_eop_then_wb: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_valid && tx_ready && tx_data == EOP_CHAR |=> state_q == ST_WB)
    else $error("end marker not followed by write-back");

endmodule : spw_tx_desc_dma

// ===== sim/tx_far_model.sv
// Far side of the engine: word memory behind the request port, stalling link sink.
// Assumes the engine holds mem_req until acked and tx_valid until accepted.
`timescale 1ns/1ps
module tx_far_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  output logic             tx_ready
);
  // ==========================================================
  // Memory, 4 KB, answers after 0 to 3 idle cycles
  logic [31:0] mem [0:1023];
  int          wait_q;

  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 32'h0000_0000;
    tx_ready  = 1'b0;
    wait_q    = 0;
    for (int i = 0; i < 1024; i++) mem[i] = 32'h0000_0000;
  end

  always @(posedge clk_sys) begin
    if (mem_req && !mem_ack && wait_q == 0) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr[11:2]];
      if (mem_we) mem[mem_addr[11:2]] <= mem_wdata;
      wait_q    <= $urandom % 4;
    end else begin
      mem_ack   <= 1'b0;
      // Toggle so stale data is never mistaken for an answer
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wait_q <= wait_q - 1;
    end
    // ==========================================================
    // Sink stalls about one cycle in four
    tx_ready <= ($urandom % 4) != 0;
  end
endmodule : tx_far_model

// ===== sim/tb_top.sv
// Self-checking bench for the transmit descriptor engine.
// Assumes the far-side model in tx_far_model and zero-wait AHB answers.
`timescale 1ns/1ps
module tb_top;
  import tx_dma_pkg::*;
  localparam logic [31:0] TBL = 32'h0000_0400;
  logic        clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic [1:0]  htrans;
  logic        mem_req, mem_we, mem_ack, tx_valid, tx_ready, link_error, irq_pulse;
  logic [8:0]  tx_data;
  logic [8:0]  got_q[$], exp_q[$];
  int          n_fail, checks_done, irq_n, cyc, seed_v;

  assign hready = hreadyout;

  spw_tx_desc_dma dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .link_error(link_error), .irq_pulse(irq_pulse));
  tx_far_model m_u (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .tx_ready(tx_ready));

  // ==========================================================
  // Clock, monitor and timeout
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got_q.push_back(tx_data);
    if (irq_pulse === 1'b1) irq_n++;
    cyc++;
    if (cyc > 30000) begin
      n_fail++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run;
    end
  end

  // ==========================================================
  // Helpers
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ 8'hE0) : (r >> 1);
    return r;
  endfunction : crc_step

  function automatic logic [7:0] mbyte(input logic [31:0] a);
    return 8'(m_u.mem[a[11:2]] >> (8 * (3 - a[1:0])));
  endfunction : mbyte

  task automatic fill(input logic [31:0] a, input int n);
    for (int i = 0; i < n; i++) m_u.mem[a[11:2] + ((a[1:0] + i) >> 2)][8 * (3 - ((a[1:0] + i)
      % 4)) +: 8] <= 8'($urandom);
  endtask : fill

  task automatic set_desc(input int i, input logic [31:0] w0, ha, dl, da);
    m_u.mem[256 + i * 4]     <= w0;
    m_u.mem[256 + i * 4 + 1] <= ha;
    m_u.mem[256 + i * 4 + 2] <= dl;
    m_u.mem[256 + i * 4 + 3] <= da;
  endtask : set_desc

  // Expected characters of descriptor i, read before the engine runs
  task automatic expect_pkt(input int i);
    logic [31:0] w0, ha, dl, da;
    logic [7:0]  c;
    w0 = m_u.mem[256 + i * 4];
    ha = m_u.mem[256 + i * 4 + 1];
    dl = m_u.mem[256 + i * 4 + 2] & 32'h00FF_FFFF;
    da = m_u.mem[256 + i * 4 + 3];
    if (w0[7:0] == 8'h00 && dl == 0) return;
    c = 8'h00;
    for (int k = 0; k < w0[7:0]; k++) begin
      exp_q.push_back({1'b0, mbyte(ha + k)});
      if (k >= w0[11:8]) c = crc_step(c, mbyte(ha + k));
    end
    if (w0[16] && w0[7:0] != 0) exp_q.push_back({1'b0, c});
    c = 8'h00;
    for (int k = 0; k < dl; k++) begin
      exp_q.push_back({1'b0, mbyte(da + k)});
      c = crc_step(c, mbyte(da + k));
    end
    if (w0[16] && dl != 0) exp_q.push_back({1'b0, c});
    exp_q.push_back(EOP_CHAR);
  endtask : expect_pkt

  task automatic wait_idle;
    logic [31:0] r;
    r = 32'h0000_0001;
    while (r[CTRL_EN_BIT] !== 1'b0 || r[CTRL_BUSY_BIT] !== 1'b0)
      ahb(1'b0, {24'h0, CTRL_OFF}, 32'h0, r);
    repeat (4) @(posedge clk_sys);
    check(32'(got_q.size()), 32'(exp_q.size()), "char count");
    foreach (exp_q[i])
      if (i < got_q.size()) check({23'h0, got_q[i]}, {23'h0, exp_q[i]}, "char");
    got_q.delete();
    exp_q.delete();
  endtask : wait_idle

  // ==========================================================
  // Scenarios
  initial begin
    {rst_n, hsel, hwrite, link_error} = 4'h0;
    {haddr, hwdata, htrans} = '0;
    {n_fail, checks_done, irq_n, cyc} = '0;
    seed_v = $urandom(61);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    ahb(1'b0, {24'h0, CTRL_OFF}, 32'h0, rd);
    check(rd, RESET_WORD, "ctrl reset");
    check({31'h0, hresp}, 32'h0, "okay response");
    ahb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h0000_0008, 32'h0, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    ahb(1'b1, {24'h0, TBASE_OFF}, TBL, rd);
    ahb(1'b0, {24'h0, TBASE_OFF}, 32'h0, rd);
    check(rd, TBL, "table base");
    $display("test registers done");
    fill(32'h0000_0801, 3);
    fill(32'h0000_0903, 5);
    fill(32'h0000_0A02, 4);
    set_desc(0, 32'h0001_D103, 32'h0000_0801, 32'h5, 32'h0000_0903);
    set_desc(1, 32'h0000_5000, 32'h0, 32'h0, 32'h0);
    set_desc(2, 32'h0001_0000, 32'h0, 32'h4, 32'h0000_0A02);
    set_desc(3, 32'h0, 32'h0, 32'h0, 32'h0);
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++) expect_pkt(i);
    ahb(1'b1, {24'h0, CTRL_OFF}, 32'h0000_0003, rd);
    repeat (5) @(posedge clk_sys);
    m_u.mem[264] <= 32'h0001_1000;
    wait_idle;
    check(m_u.mem[256], 32'h0001_4103, "desc0 written back");
    check(m_u.mem[260], 32'h0000_4000, "desc1 written back");
    check(m_u.mem[264], 32'h0001_0000, "desc2 written back");
    check(irq_n, 2, "interrupts");
    ahb(1'b0, {24'h0, TBASE_OFF}, 32'h0, rd);
    check(rd, TBL | 32'h30, "pointer");
    ahb(1'b0, {24'h0, CTRL_OFF}, 32'h0, rd);
    check(rd, 32'h0000_0006, "ctrl after run");
    ahb(1'b1, {24'h0, CTRL_OFF}, 32'h0000_0004, rd);
    ahb(1'b0, {24'h0, CTRL_OFF}, 32'h0, rd);
    check(rd, 32'h0000_0000, "sent flag cleared");
    $display("test three packets done");
    irq_n = 0;
    fill(32'h0000_0B03, 2);
    set_desc(3, 32'h0000_7002, 32'h0000_0B03, 32'h0, 32'h0);
    @(posedge clk_sys);
    expect_pkt(3);
    ahb(1'b1, {24'h0, CTRL_OFF}, 32'h0000_0001, rd);
    while (tx_valid !== 1'b1) @(posedge clk_sys);
    link_error <= 1'b1;
    @(posedge clk_sys);
    link_error <= 1'b0;
    wait_idle;
    check(m_u.mem[268], 32'h0000_E002, "desc3 link error");
    check(irq_n, 0, "masked interrupt");
    ahb(1'b0, {24'h0, TBASE_OFF}, 32'h0, rd);
    check(rd, TBL, "wrapped pointer");
    ahb(1'b0, {24'h0, CTRL_OFF}, 32'h0, rd);
    check(rd, 32'h0000_0004, "ctrl after wrap");
    $display("test wrap and link error done");
    complete_run;
  end
endmodule : tb_top
